/* sdacr_pkg.sv */
// Shared constants and types for the converter register and control block
package sdacr_pkg;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] OFS_OFFSET_TRIM = 8'h14;
  localparam logic [7:0] OFS_GAIN_TRIM   = 8'h18;
  localparam logic [7:0] OFS_SHIFT_TRIM  = 8'h1A;
  localparam logic [7:0] OFS_TRIGGER     = 8'h1C;
  localparam logic [7:0] OFS_BUSY        = 8'h20;
  localparam logic [7:0] OFS_RESULT      = 8'h24;
  localparam logic [7:0] OFS_SEQUENCE    = 8'h28;
  localparam logic [7:0] OFS_ANALOG      = 8'h2C;
  localparam logic [7:0] OFS_DEBUG       = 8'h2E;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int unsigned OFFSET_W   = 24;
  localparam int unsigned GAIN_W     = 14;
  localparam int unsigned SHIFT_W    = 4;
  localparam int unsigned RESULT_W   = 24;
  localparam int unsigned SEQ_W      = 3;
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned ANA_W      = 8;
  localparam int unsigned BIAS_W     = 5;
  localparam int unsigned TRIG_FLUSH = 0;
  localparam int unsigned TRIG_START = 1;
  localparam int unsigned ANA_CHOP   = 6;
  localparam int unsigned ANA_BUFT   = 7;
  localparam int unsigned DBG_RUN    = 0;
  localparam int unsigned EXT_BUSY_W = 7;

  // Crossing slots; busy bit of slot i sits at EXT_BUSY_W + i
  localparam int unsigned SYN_OFFSET = 0;
  localparam int unsigned SYN_GAIN   = 1;
  localparam int unsigned SYN_SHIFT  = 2;
  localparam int unsigned SYN_TRIG   = 3;
  localparam int unsigned SYN_ANALOG = 4;
  localparam int unsigned NSYNC      = 5;

  // ---------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [13:0] GAIN_RESET   = 14'h0001;
  localparam logic [1:0]  SYNC_CYCLES  = 2'h3;
  localparam logic [2:0]  FLUSH_CYCLES = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_FLUSH = 2'b10
  } sdacr_state_t;

endpackage

/* sdacr_corrector.sv */
// Offset, gain and shift correction of one raw conversion value
`timescale 1ns/10ps
module sdacr_corrector
  import sdacr_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // Raw sample in
  input  wire logic                    in_valid,
  input  wire logic [RESULT_W-1:0]     raw,
  // Correction settings
  input  wire logic [OFFSET_W-1:0]     offset_trim,
  input  wire logic [GAIN_W-1:0]       gain_trim,
  input  wire logic [SHIFT_W-1:0]      shift_trim,
  // Corrected sample out
  output logic                         out_valid,
  output logic [RESULT_W-1:0]          out_data
);

  logic signed [RESULT_W:0]            sum;
  logic signed [RESULT_W+GAIN_W+1:0]   prod;
  logic signed [RESULT_W+GAIN_W+1:0]   scaled;
  logic signed [RESULT_W+GAIN_W+1:0]   hi_lim;
  logic signed [RESULT_W+GAIN_W+1:0]   lo_lim;
  logic [RESULT_W-1:0]                 sat;

  // Saturate rather than wrap so a large gain cannot flip the sign
  always_comb
  begin
    sum    = $signed({raw[RESULT_W-1], raw})
           + $signed({offset_trim[OFFSET_W-1], offset_trim});
    prod   = sum * $signed({1'b0, gain_trim});
    scaled = prod >>> shift_trim;
    hi_lim = $signed({{(GAIN_W+2){1'b0}}, 1'b0,
                      {(RESULT_W-1){1'b1}}});
    lo_lim = $signed({{(GAIN_W+2){1'b1}}, 1'b1,
                      {(RESULT_W-1){1'b0}}});
    if (scaled > hi_lim)
      sat = {1'b0, {(RESULT_W-1){1'b1}}};
    else if (scaled < lo_lim)
      sat = {1'b1, {(RESULT_W-1){1'b0}}};
    else
      sat = scaled[RESULT_W-1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_data <= sat;
    end
  end

endmodule // sdacr_corrector

/* sdacr_ctrl.sv */
// Register file, trigger sequencing and result path of the converter
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps

module sdacr_ctrl
  import sdacr_pkg::*;
#(
  parameter int unsigned RAW_W = 16
)
(
  // Clock and resets
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  input  wire logic                            sw_reset,
  // Register port
  input  wire logic [sdacr_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [sdacr_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [sdacr_pkg::DATA_W-1:0]    reg_rdata,
  // Modulator side
  input  wire logic                            raw_valid,
  input  wire logic [RAW_W-1:0]                raw_data,
  output logic                                 conv_start,
  output logic                                 conv_flush,
  output logic      [sdacr_pkg::SEL_W-1:0]     input_select,
  output logic                                 input_chopper_on,
  output logic      [sdacr_pkg::BIAS_W-1:0]    bias_current_setting,
  output logic                                 buffer_test_bit,
  // Debug and neighbouring busy flags
  input  wire logic                            dbg_halt,
  output logic                                 conv_halt,
  input  wire logic [sdacr_pkg::EXT_BUSY_W-1:0] ext_busy
);
  import sdacr_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [OFFSET_W-1:0]        off_sh;
    logic [GAIN_W-1:0]          gain_sh;
    logic [SHIFT_W-1:0]         shift_sh;
    logic [ANA_W-1:0]           ana_sh;
    logic [1:0]                 trig_sh;
    logic [OFFSET_W-1:0]        off;
    logic [GAIN_W-1:0]          gain;
    logic [SHIFT_W-1:0]         shift;
    logic [ANA_W-1:0]           ana;
    logic                       start_req;
    logic                       flush_req;
    logic [NSYNC-1:0][1:0]      cnt;
    logic [SEQ_W-1:0]           mask;
    logic                       run_dbg;
    sdacr_state_t               state;
    logic [SEL_W-1:0]           seq_sel;
    logic [2:0]                 flush_cnt;
    logic                       flush_conv;
    logic [2:0]                 halt_sync;
    logic                       halt_f;
    logic                       conv_halt;
    logic                       conv_start;
    logic                       conv_flush;
    logic [RESULT_W-1:0]        result;
    logic [DATA_W-1:0]          rdata;
  } sdacr_regs_t;

  sdacr_regs_t                  q;
  sdacr_regs_t                  next_q;
  logic                         corr_in_valid;
  logic                         corr_valid;
  logic [RESULT_W-1:0]          corr_data;
  logic [RESULT_W-1:0]          raw_adj;
  logic [NSYNC-1:0]             busy;
  logic [SEL_W:0]               pick_first;
  logic [SEL_W:0]               pick_next;

  // Lowest enabled input at or above from_bit; top bit says found
  function automatic logic [SEL_W:0] seq_pick(
    input logic [SEQ_W-1:0] mask,
    input logic [SEL_W:0]   from_bit
  );
    logic [SEL_W:0] res;
    res = '0;
    for (int i = SEQ_W - 1; i >= 0; i--)
    begin
      if (mask[i] && (i >= int'(from_bit)))
        res = {1'b1, SEL_W'(i)};
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  assign raw_adj = {raw_data, {(RESULT_W-RAW_W){1'b0}}};

  always_comb
  begin
    for (int i = 0; i < NSYNC; i++)
      busy[i] = (q.cnt[i] != 2'h0);
    pick_first = seq_pick(q.mask, '0);
    pick_next  = seq_pick(q.mask, {1'b0, q.seq_sel} + 3'h1);
    corr_in_valid = (q.state == ST_CONV) && raw_valid
                    && !q.conv_halt && !q.flush_req;
  end

  sdacr_corrector u_corr (
    .clk_sys     (clk_sys),
    .resetn      (resetn && !sw_reset),
    .in_valid    (corr_in_valid),
    .raw         (raw_adj),
    .offset_trim (q.off),
    .gain_trim   (q.gain),
    .shift_trim  (q.shift),
    .out_valid   (corr_valid),
    .out_data    (corr_data)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    next_q.conv_start = 1'b0;
    next_q.conv_flush = 1'b0;
    next_q.rdata      = '0;

    // First stage feeds only the second; stages two and three must agree
    next_q.halt_sync = {q.halt_sync[1:0], dbg_halt};
    if (q.halt_sync[2] == q.halt_sync[1])
      next_q.halt_f = q.halt_sync[2];
    next_q.conv_halt = q.halt_f && !q.run_dbg;

    // Crossing delay: the settings reach the core when the count expires
    for (int i = 0; i < NSYNC; i++)
    begin
      if (q.cnt[i] != 2'h0)
        next_q.cnt[i] = q.cnt[i] - 2'h1;
    end
    if (q.cnt[SYN_OFFSET] == 2'h1)
      next_q.off = q.off_sh;
    if (q.cnt[SYN_GAIN] == 2'h1)
      next_q.gain = q.gain_sh;
    if (q.cnt[SYN_SHIFT] == 2'h1)
      next_q.shift = q.shift_sh;
    if (q.cnt[SYN_ANALOG] == 2'h1)
      next_q.ana = q.ana_sh;
    if (q.cnt[SYN_TRIG] == 2'h1)
    begin
      next_q.start_req = q.start_req | q.trig_sh[TRIG_START];
      next_q.flush_req = q.flush_req | q.trig_sh[TRIG_FLUSH];
      next_q.trig_sh   = 2'h0;
    end

    // Trim, analog and trigger writes restart their crossing; sequence and debug writes apply at once
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_OFFSET_TRIM:
        begin
          next_q.off_sh = reg_wdata[OFFSET_W-1:0];
          next_q.cnt[SYN_OFFSET] = SYNC_CYCLES;
        end
        OFS_GAIN_TRIM:
        begin
          next_q.gain_sh = reg_wdata[GAIN_W-1:0];
          next_q.cnt[SYN_GAIN] = SYNC_CYCLES;
        end
        OFS_SHIFT_TRIM:
        begin
          next_q.shift_sh = reg_wdata[SHIFT_W-1:0];
          next_q.cnt[SYN_SHIFT] = SYNC_CYCLES;
        end
        OFS_ANALOG:
        begin
          next_q.ana_sh = reg_wdata[ANA_W-1:0];
          next_q.cnt[SYN_ANALOG] = SYNC_CYCLES;
        end
        OFS_TRIGGER:
        begin
          if (reg_wdata[TRIG_START] && !q.trig_sh[TRIG_START]
              && !q.start_req)
            next_q.trig_sh[TRIG_START] = 1'b1;
          if (reg_wdata[TRIG_FLUSH])
            next_q.trig_sh[TRIG_FLUSH] = 1'b1;
          next_q.cnt[SYN_TRIG] = SYNC_CYCLES;
        end
        OFS_SEQUENCE:
          next_q.mask = reg_wdata[SEQ_W-1:0];
        OFS_DEBUG:
          next_q.run_dbg = reg_wdata[DBG_RUN];
        default:
        begin
        end
      endcase
    end

    // Flush wins over every other step of the sequencer
    if (q.flush_req)
    begin
      next_q.flush_req  = 1'b0;
      next_q.conv_flush = 1'b1;
      next_q.state      = ST_FLUSH;
      next_q.flush_cnt  = FLUSH_CYCLES;
      next_q.flush_conv = (q.state == ST_CONV)
                          || ((q.state == ST_FLUSH) && q.flush_conv);
    end
    else
    begin
      case (q.state)
        ST_IDLE:
        begin
          if (q.start_req && !q.conv_halt)
          begin
            next_q.start_req  = 1'b0;
            next_q.conv_start = 1'b1;
            next_q.seq_sel    = pick_first[SEL_W-1:0];
            next_q.state      = ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (raw_valid && !q.conv_halt)
          begin
            if (pick_next[SEL_W])
            begin
              next_q.seq_sel    = pick_next[SEL_W-1:0];
              next_q.conv_start = 1'b1;
            end
            else
              next_q.state = ST_IDLE;
          end
        end
        ST_FLUSH:
        begin
          if (q.flush_cnt == 3'h1)
          begin
            next_q.state      = q.flush_conv ? ST_CONV : ST_IDLE;
            next_q.conv_start = q.flush_conv;
          end
          else
            next_q.flush_cnt = q.flush_cnt - 3'h1;
        end
        default:
          next_q.state = ST_IDLE;
      endcase
    end

    // A result still in the corrector during a flush is dropped
    if (corr_valid && (q.state != ST_FLUSH) && !q.flush_req)
      next_q.result = corr_data;

    if (reg_rd)
    begin
      case (reg_addr)
        OFS_OFFSET_TRIM: next_q.rdata = DATA_W'(q.off_sh);
        OFS_GAIN_TRIM:   next_q.rdata = DATA_W'(q.gain_sh);
        OFS_SHIFT_TRIM:  next_q.rdata = DATA_W'(q.shift_sh);
        OFS_TRIGGER:
          next_q.rdata = DATA_W'({q.trig_sh[TRIG_START] | q.start_req,
                                  q.trig_sh[TRIG_FLUSH] | q.flush_req});
        OFS_BUSY:        next_q.rdata = DATA_W'({busy, ext_busy});
        OFS_RESULT:      next_q.rdata = DATA_W'(q.result);
        OFS_SEQUENCE:    next_q.rdata = DATA_W'(q.mask);
        OFS_ANALOG:      next_q.rdata = DATA_W'(q.ana_sh);
        OFS_DEBUG:       next_q.rdata = DATA_W'(q.run_dbg);
        default:         next_q.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || sw_reset)
    begin
      q         <= '0;
      q.gain    <= GAIN_RESET;
      q.gain_sh <= GAIN_RESET;
    end
    else
      q <= next_q;
  end

  assign reg_rdata            = q.rdata;
  assign conv_start           = q.conv_start;
  assign conv_flush           = q.conv_flush;
  assign conv_halt            = q.conv_halt;
  assign input_select         = q.seq_sel;
  assign input_chopper_on     = q.ana[ANA_CHOP];
  assign bias_current_setting = q.ana[BIAS_W-1:0];
  assign buffer_test_bit      = q.ana[ANA_BUFT];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn || sw_reset);

  sequence s_shift_write;
    reg_wr && (reg_addr == OFS_SHIFT_TRIM);
  endsequence

  sequence s_busy_window;
    busy[SYN_SHIFT] [*3] ##1 !busy[SYN_SHIFT];
  endsequence

  a_shift_busy_window: assert property (
    s_shift_write |=> s_busy_window)
    else $error("shift busy window wrong");

  a_shift_busy_span: assert property (
    (s_shift_write ##1 (!(reg_wr && reg_addr == OFS_SHIFT_TRIM)) [*3])
      |=> !busy[SYN_SHIFT] && (q.shift == $past(reg_wdata[3:0], 4)))
    else $error("shift value not committed after crossing");

  a_start_clears: assert property (
    (q.state == ST_IDLE) && q.start_req && !q.conv_halt && !q.flush_req
      |=> conv_start && !q.start_req && (q.state == ST_CONV))
    else $error("start did not begin conversion");

  a_flush_aborts: assert property (
    q.flush_req |=> conv_flush && (q.state == ST_FLUSH)
      ##4 (q.state != ST_FLUSH))
    else $error("flush sequence wrong length");

  a_flush_resumes: assert property (
    q.flush_req && (q.state == ST_CONV)
      |=> ##4 conv_start && (q.state == ST_CONV))
    else $error("pending conversion not restarted");

  a_result_holds: assert property (
    $changed(q.result) && $past(resetn) && !$past(sw_reset)
      |-> $past(corr_valid))
    else $error("result changed without a conversion end");

  a_no_sequence: assert property (
    (q.mask == 3'h0) && (q.state == ST_CONV) && raw_valid
      && !q.conv_halt && !q.flush_req |=> (q.state == ST_IDLE))
    else $error("stepping with empty mask");

  a_halt_gate: assert property (
    q.halt_f && !q.run_dbg ##1 !sw_reset |-> conv_halt)
    else $error("converter not halted under debugger");

  a_read_busy: assert property (
    reg_rd && (reg_addr == OFS_BUSY)
      |=> reg_rdata[EXT_BUSY_W-1:0] == $past(ext_busy))
    else $error("neighbour busy bits misplaced");

endmodule // sdacr_ctrl

/* tb_sdacr_ctrl.sv */
// Self-checking testbench for the converter register and control block
`timescale 1ns/10ps
module tb_sdacr_ctrl;
  import sdacr_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  clk_sys = 1'b0;
  logic                  resetn;
  logic                  sw_reset;
  logic [ADDR_W-1:0]     reg_addr;
  logic [DATA_W-1:0]     reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [DATA_W-1:0]     reg_rdata;
  logic                  raw_valid;
  logic [15:0]           raw_data;
  logic                  conv_start;
  logic                  conv_flush;
  logic [SEL_W-1:0]      input_select;
  logic                  input_chopper_on;
  logic [BIAS_W-1:0]     bias_current_setting;
  logic                  buffer_test_bit;
  logic                  dbg_halt;
  logic                  conv_halt;
  logic [EXT_BUSY_W-1:0] ext_busy;
  logic                  rd_d = 1'b0;
  logic [31:0]           exp_q[$];
  int                    err_total = 0;
  int                    tests_run = 0;
  int                    n_start = 0;
  int                    n_flush = 0;
  int                    cyc = 0;
  int                    base;
  int                    basef;
  logic [23:0]           off;
  logic [13:0]           gain;
  logic [3:0]            shft;
  logic [15:0]           raw;
  logic [23:0]           res;
  logic [7:0]            ana;
  logic [7:0]            ofs [9] = '{OFS_OFFSET_TRIM, OFS_GAIN_TRIM,
    OFS_SHIFT_TRIM, OFS_BUSY, OFS_RESULT, OFS_SEQUENCE, OFS_ANALOG,
    OFS_DEBUG, 8'h30};

  sdacr_ctrl #(.RAW_W(16)) sdacr_ctrl_inst (
    .clk_sys(clk_sys), .resetn(resetn), .sw_reset(sw_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
    .raw_data(raw_data), .conv_start(conv_start),
    .conv_flush(conv_flush), .input_select(input_select),
    .input_chopper_on(input_chopper_on),
    .bias_current_setting(bias_current_setting),
    .buffer_test_bit(buffer_test_bit), .dbg_halt(dbg_halt),
    .conv_halt(conv_halt), .ext_busy(ext_busy)
  );

  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Notes the expected word; the monitor compares it a cycle later
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask

  // Crossing walk: busy bit up right after the write, down after it lands
  task automatic sync_wr(input logic [7:0] a, input logic [31:0] d,
                         input int slot, input logic [31:0] rb);
    wr(a, d);
    rd(OFS_BUSY, (32'h0000_0001 << (EXT_BUSY_W + slot)) | 32'(ext_busy));
    repeat (2) @(posedge clk_sys);
    rd(OFS_BUSY, 32'(ext_busy));
    rd(a, rb);
  endtask

  task automatic raw_pulse(input logic [15:0] r);
    @(posedge clk_sys);
    raw_data  <= r;
    raw_valid <= 1'b1;
    @(posedge clk_sys);
    raw_valid <= 1'b0;
    raw_data  <= ~r;
  endtask

  task automatic wait_start(input logic [1:0] sel);
    int i;
    i = 0;
    @(negedge clk_sys);
    while (conv_start !== 1'b1 && i < 30)
    begin
      @(negedge clk_sys);
      i++;
    end
    check(32'(conv_start), 32'h0000_0001);
    check(32'(input_select), 32'(sel));
  endtask

  // Sum kept well inside 24 bits by the stimulus ranges, so no wrap
  function automatic logic [23:0] corr(input logic [15:0] r);
    longint v;
    v = longint'($signed({r, 8'h00})) + longint'($signed(off));
    v = (v * longint'(gain)) >>> shft;
    if (v > 64'sh0000_0000_007F_FFFF)
      v = 64'sh0000_0000_007F_FFFF;
    else if (v < -64'sh0000_0000_0080_0000)
      v = -64'sh0000_0000_0080_0000;
    return 24'(v);
  endfunction

  // ----------------------------------------------------------------
  // Monitor, pulse counters and timeout
  // ----------------------------------------------------------------
  always @(negedge clk_sys)
  begin
    if (rd_d)
      check(reg_rdata, exp_q.pop_front());
  end

  always @(posedge clk_sys)
  begin
    rd_d <= reg_rd;
    cyc  <= cyc + 1;
    if (conv_start === 1'b1)
      n_start <= n_start + 1;
    if (conv_flush === 1'b1)
      n_flush <= n_flush + 1;
    if (cyc == 3000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn    = 1'b0;
    sw_reset  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    raw_valid = 1'b0;
    raw_data  = 16'h0000;
    dbg_halt  = 1'b0;
    ext_busy  = 7'h00;
    void'($urandom(32'h6507_8396));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (ofs[i])
      rd(ofs[i], (ofs[i] == OFS_GAIN_TRIM) ? 32'h0000_0001 : 32'h0000_0000);
    // Trims and analog settings through the crossing
    ext_busy <= 7'($urandom);
    off  = 24'($urandom_range(0, 65535)) - 24'h00_8000;
    gain = 14'($urandom_range(1, 16383));
    shft = 4'($urandom);
    ana  = 8'($urandom) & 8'hDF;
    sync_wr(OFS_OFFSET_TRIM, {8'hFF, off}, SYN_OFFSET, {8'h00, off});
    sync_wr(OFS_GAIN_TRIM, {18'h3_FFFF, gain}, SYN_GAIN, {18'h0_0000, gain});
    sync_wr(OFS_SHIFT_TRIM, {28'hFFF_FFFF, shft}, SYN_SHIFT, 32'(shft));
    sync_wr(OFS_ANALOG, {24'hFF_FFFF, ana}, SYN_ANALOG, 32'(ana));
    @(negedge clk_sys);
    check(32'(input_chopper_on), 32'(ana[6]));
    check(32'(bias_current_setting), 32'(ana[4:0]));
    check(32'(buffer_test_bit), 32'(ana[7]));
    // Zero bits in the trigger do nothing
    base  = n_start;
    basef = n_flush;
    wr(OFS_TRIGGER, 32'hFFFF_FFFC);
    repeat (12) @(posedge clk_sys);
    check(32'(n_start - base), 32'h0000_0000);
    check(32'(n_flush - basef), 32'h0000_0000);
    // Start twice back to back, empty mask: one plain conversion
    wr(OFS_TRIGGER, 32'h0000_0002);
    wr(OFS_TRIGGER, 32'h0000_0002);
    rd(OFS_BUSY, 32'h0000_0400 | 32'(ext_busy));
    wait_start(2'h0);
    raw = 16'($urandom_range(0, 32767)) - 16'h4000;
    raw_pulse(raw);
    repeat (10) @(posedge clk_sys);
    check(32'(n_start - base), 32'h0000_0001);
    rd(OFS_RESULT, {8'h00, corr(raw)});
    // Sequence over inputs 0 and 2
    wr(OFS_SEQUENCE, 32'hFFFF_FFFD);
    rd(OFS_SEQUENCE, 32'h0000_0005);
    base = n_start;
    wr(OFS_TRIGGER, 32'h0000_0002);
    wait_start(2'h0);
    raw = 16'($urandom_range(0, 32767)) - 16'h4000;
    raw_pulse(raw);
    wait_start(2'h2);
    rd(OFS_RESULT, {8'h00, corr(raw)});
    raw = 16'($urandom_range(0, 32767)) - 16'h4000;
    raw_pulse(raw);
    res = corr(raw);
    repeat (10) @(posedge clk_sys);
    check(32'(n_start - base), 32'h0000_0002);
    rd(OFS_RESULT, {8'h00, res});
    // Flush in mid-conversion; raw sample arriving during it is dropped
    wr(OFS_SEQUENCE, 32'h0000_0000);
    base  = n_start;
    basef = n_flush;
    wr(OFS_TRIGGER, 32'h0000_0002);
    wait_start(2'h0);
    wr(OFS_TRIGGER, 32'h0000_0001);
    repeat (4) @(posedge clk_sys);
    raw_pulse(16'h1234);
    repeat (12) @(posedge clk_sys);
    check(32'(n_flush - basef), 32'h0000_0001);
    check(32'(n_start - base), 32'h0000_0002);
    rd(OFS_RESULT, {8'h00, res});
    raw = 16'($urandom_range(0, 32767)) - 16'h4000;
    raw_pulse(raw);
    repeat (3) @(posedge clk_sys);
    rd(OFS_RESULT, {8'h00, corr(raw)});
    // Flush while idle: no conversion was running, so none restarts
    base  = n_start;
    basef = n_flush;
    wr(OFS_TRIGGER, 32'h0000_0001);
    repeat (12) @(posedge clk_sys);
    check(32'(n_flush - basef), 32'h0000_0001);
    check(32'(n_start - base), 32'h0000_0000);
    // Debugger halt, run bit and software reset
    dbg_halt <= 1'b1;
    repeat (8) @(negedge clk_sys);
    check(32'(conv_halt), 32'h0000_0001);
    wr(OFS_DEBUG, 32'h0000_0001);
    rd(OFS_DEBUG, 32'h0000_0001);
    repeat (3) @(negedge clk_sys);
    check(32'(conv_halt), 32'h0000_0000);
    @(posedge clk_sys);
    sw_reset <= 1'b1;
    @(posedge clk_sys);
    sw_reset <= 1'b0;
    rd(OFS_DEBUG, 32'h0000_0000);
    rd(OFS_GAIN_TRIM, 32'h0000_0001);
    repeat (8) @(negedge clk_sys);
    check(32'(conv_halt), 32'h0000_0001);
    dbg_halt <= 1'b0;
    repeat (4) @(posedge clk_sys);
    finish_test();
  end

endmodule // tb_sdacr_ctrl
